/* ksx_cfg.svh */
// constants for the slot keystream exclusive-or mapper: bit positions,
// segment lengths and field layouts, shared by both ends.
// assumes: included by the package and by the slot framing end by bare name.
`ifndef KSX_CFG_SVH
`define KSX_CFG_SVH

// ****************************************************************
// keystream segment layout
// ****************************************************************
`define KSX_POS_W          11
`define KSX_TAIL_LEN       11'h028
`define KSX_TAIL_FIRST_BIT 6'h08
`define KSX_HALF_BASE      11'h078
`define KSX_DOUBLE_LEN     11'h348
`define KSX_SEG_PER_FRAME  2

// ****************************************************************
// payload layouts
// ****************************************************************
`define KSX_HALF_PAYLOAD   11'h050
`define KSX_DOUBLE_PAYLOAD 11'h320
`define KSX_SUB_PITCH      11'h050
`define KSX_SUB_DATA       11'h040
`define KSX_SUB_CHECK      11'h010
`define KSX_SINGLE_DATA    11'h300
`define KSX_SINGLE_CHECK   11'h020
`define KSX_SINGLE_TRAIL   11'h004

`endif

/* ksx_keystream_end.sv */
// keystream end: cuts the raw keystream into the two segments of a frame
// and marks every keystream bit as applied or unused for the slot format.
// assumes: raw keystream bits come from generator logic on the same clock.
`timescale 1ns/10ps

module ksx_keystream_end
  import ksx_pkg::*;
#(
  parameter int J_W = 6
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ce,
  input  wire logic           start,
  input  wire ksx_slot_t      cfg_slot,
  input  wire ksx_fmt_t       cfg_fmt,
  input  wire logic           cfg_tail_ctl,
  input  wire logic           cfg_encrypt,
  input  wire logic [J_W-1:0] cfg_j,
  input  wire logic           kin_valid,
  output logic                kin_ready,
  input  wire logic           kin_bit,
  output logic                busy,
  output logic                done,
  output logic                cfg_error,
  ksx_link_if.gen             link
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (J_W < 1 || J_W > 8) begin : g_bad_jw
    $error("ksx_keystream_end: J_W must lie in 1..8");
  end

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } ksx_gen_state_t;

  ksx_gen_state_t state_reg;
  ksx_slot_t      slot_reg;
  ksx_fmt_t       fmt_reg;
  logic           tail_ctl_reg;
  logic           encrypt_reg;
  logic [7:0]     j_reg;
  ksx_pos_t       len_reg;
  ksx_pos_t       pos_reg;
  logic           seg_reg;
  logic           out_valid_reg;
  logic           out_bit_reg;
  logic           out_apply_reg;
  ksx_pos_t       out_pos_reg;
  logic           out_seg_reg;
  logic           out_last_reg;
  logic           done_reg;
  logic           err_reg;

  logic           take;
  logic           last_bit;
  logic           start_ok;
  logic           cfg_legal;

  // ****************************************************************
  // handshakes
  // ****************************************************************
  // one output stage; a bit is taken only when that stage can hold it.
  // ready falls with ce so a frozen cycle never looks like a take
  assign kin_ready = ce && (state_reg == ST_RUN) && (!out_valid_reg || link.ks_ready);
  assign take      = ce && kin_valid && kin_ready;
  assign last_bit  = seg_reg && (pos_reg == ksx_pos_t'(len_reg - 11'h001));

  // single subfield exists only on double slots, and j only on half slots
  assign cfg_legal = !(cfg_fmt == KSX_FMT_SINGLE && cfg_slot == KSX_SLOT_HALF)
                     && (cfg_fmt != KSX_FMT_SINGLE + 2'h1)
                     && !(cfg_slot == KSX_SLOT_DOUBLE && cfg_j != '0);
  assign start_ok  = ce && start && state_reg == ST_IDLE && !out_valid_reg;

  assign busy      = (state_reg == ST_RUN) || out_valid_reg;
  assign done      = done_reg;
  assign cfg_error = err_reg;

  assign link.ks_valid = out_valid_reg;
  assign link.ks_bit   = out_bit_reg;
  assign link.ks_apply = out_apply_reg;
  assign link.ks_pos   = out_pos_reg;
  assign link.ks_seg   = out_seg_reg;
  assign link.ks_last  = out_last_reg;

  // ****************************************************************
  // frame control
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_ok && cfg_legal) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (take && last_bit) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // configuration is frozen for the whole frame so both segments match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_reg     <= KSX_SLOT_HALF;
      fmt_reg      <= KSX_FMT_UNPROT;
      tail_ctl_reg <= 1'b0;
      encrypt_reg  <= 1'b0;
      j_reg        <= 8'h00;
      len_reg      <= '0;
    end else if (start_ok && cfg_legal) begin
      slot_reg     <= cfg_slot;
      fmt_reg      <= cfg_fmt;
      tail_ctl_reg <= cfg_tail_ctl;
      encrypt_reg  <= cfg_encrypt;
      j_reg        <= 8'(cfg_j);
      len_reg      <= ksx_seg_len(cfg_slot, 8'(cfg_j));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else if (ce) begin
      err_reg <= start && state_reg == ST_IDLE && !out_valid_reg && !cfg_legal;
    end
  end

  // ****************************************************************
  // segment walk
  // ****************************************************************
  // two segments per frame, fixed side first, each len_reg bits long
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg <= '0;
      seg_reg <= 1'b0;
    end else if (start_ok) begin
      pos_reg <= '0;
      seg_reg <= 1'b0;
    end else if (take) begin
      if (pos_reg == ksx_pos_t'(len_reg - 11'h001)) begin
        pos_reg <= '0;
        seg_reg <= !seg_reg;
      end else begin
        pos_reg <= ksx_pos_t'(pos_reg + 11'h001);
      end
    end
  end

  // ****************************************************************
  // output stage
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid_reg <= 1'b0;
    end else if (ce) begin
      if (take) begin
        out_valid_reg <= 1'b1;
      end else if (link.ks_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  // in clear mode the stream still runs so framing stays aligned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_bit_reg   <= 1'b0;
      out_apply_reg <= 1'b0;
      out_pos_reg   <= '0;
      out_seg_reg   <= 1'b0;
      out_last_reg  <= 1'b0;
    end else if (take) begin
      out_bit_reg   <= kin_bit;
      out_apply_reg <= encrypt_reg && ksx_apply(pos_reg, slot_reg, fmt_reg, tail_ctl_reg);
      out_pos_reg   <= pos_reg;
      out_seg_reg   <= seg_reg;
      out_last_reg  <= last_bit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= out_valid_reg && out_last_reg && link.ks_ready;
    end
  end

endmodule

/* ksx_link_chk.sv */
// checker on the keystream link between the two ends.
// assumes: instantiated by the bench beside the link, one clock domain.
`timescale 1ns/10ps

module ksx_link_chk
  import ksx_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst,
  input wire logic     ks_valid,
  input wire logic     ks_ready,
  input wire logic     ks_bit,
  input wire logic     ks_apply,
  input wire ksx_pos_t ks_pos,
  input wire logic     ks_seg,
  input wire logic     ks_last
);
  // ********
  // helper state
  // ********
  logic     tk;
  logic     have_reg;
  logic     lseg_reg;
  logic     a0_reg;
  logic     a40_reg;
  logic     a104_reg;
  logic     a808_reg;
  ksx_pos_t lpos_reg;
  ksx_pos_t end0_reg;

  assign tk = ks_valid && ks_ready;

  // apply seen at the first bit of each region, for later bits to match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      have_reg <= 1'b0;
      lseg_reg <= 1'b0;
      a0_reg   <= 1'b0;
      a40_reg  <= 1'b0;
      a104_reg <= 1'b0;
      a808_reg <= 1'b0;
      lpos_reg <= '0;
      end0_reg <= '0;
    end else if (tk) begin
      have_reg <= !ks_last;
      lseg_reg <= ks_seg;
      lpos_reg <= ks_pos;
      if (ks_pos == 11'h000) a0_reg <= ks_apply;
      if (ks_pos == 11'h028) a40_reg <= ks_apply;
      if (ks_pos == 11'h068) a104_reg <= ks_apply;
      if (ks_pos == 11'h328) a808_reg <= ks_apply;
      if (!ks_seg) end0_reg <= ks_pos;
    end
  end

  // ********
  // assertions
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_offer_holds: assert property (
    ks_valid && !ks_ready |=> ks_valid && $stable({ks_bit, ks_apply, ks_pos, ks_seg, ks_last}))
    else $error("link offer changed before taken");
  a_pos_order: assert property (
    ks_valid |-> (have_reg ? (ks_pos == lpos_reg + 11'h001 && ks_seg == lseg_reg)
                  || (ks_pos == 11'h000 && ks_seg && !lseg_reg) : ks_pos == 11'h000 && !ks_seg))
    else $error("keystream position out of order");
  a_seg_match: assert property (
    ks_valid && ks_last |-> ks_seg && ks_pos == end0_reg)
    else $error("second segment length differs");
  a_seg_len: assert property (
    ks_valid && ks_last |-> ks_pos == 11'h347 || (ks_pos >= 11'h077 && ks_pos <= 11'h0b6))
    else $error("segment length wrong");
  a_tail_same: assert property (
    tk && ks_pos != 11'h000 && ks_pos < 11'h028 |-> ks_apply == a0_reg)
    else $error("tail apply not uniform");
  a_data_mask: assert property (
    tk && ks_pos > 11'h028 && ks_pos < 11'h328 && ks_pos != 11'h068 |->
      ks_apply == ((ks_pos - 11'h028) % 11'h050 < 11'h040 ? a40_reg : a104_reg))
    else $error("payload apply pattern wrong");
  a_single_gap: assert property (
    tk && ks_pos > 11'h328 && !a808_reg |-> !ks_apply)
    else $error("unused tail of segment applied");
  a_gap_used: assert property (
    tk && ks_pos == 11'h068 && ks_apply |-> a40_reg)
    else $error("check position applied in clear");

  c_frame_end: cover property (tk && ks_last);
  c_single_cut: cover property (tk && ks_pos == 11'h328 && !ks_apply && a40_reg);
  c_multi_gap: cover property (tk && ks_pos == 11'h068 && !ks_apply && a40_reg);
endmodule

/* ksx_link_if.sv */
// link between the keystream end and the slot framing end.
// assumes: both ends share one clock; the testbench supplies it.
`timescale 1ns/10ps

interface ksx_link_if;
  import ksx_pkg::*;

  logic     ks_valid;
  logic     ks_ready;
  logic     ks_bit;
  logic     ks_apply;
  ksx_pos_t ks_pos;
  logic     ks_seg;
  logic     ks_last;

  modport gen (
    output ks_valid,
    input  ks_ready,
    output ks_bit,
    output ks_apply,
    output ks_pos,
    output ks_seg,
    output ks_last
  );

  modport mac (
    input  ks_valid,
    output ks_ready,
    input  ks_bit,
    input  ks_apply,
    input  ks_pos,
    input  ks_seg,
    input  ks_last
  );
endinterface

/* ksx_pkg.sv */
// types and shared mapping functions of the slot keystream mapper.
// assumes: ksx_cfg.svh is on the include path.
`include "ksx_cfg.svh"

package ksx_pkg;

  typedef logic [`KSX_POS_W-1:0] ksx_pos_t;

  typedef enum logic {
    KSX_SLOT_HALF,
    KSX_SLOT_DOUBLE
  } ksx_slot_t;

  typedef enum logic [1:0] {
    KSX_FMT_UNPROT,
    KSX_FMT_MULTI,
    KSX_FMT_SINGLE
  } ksx_fmt_t;

  // ****************************************************************
  // segment and payload lengths
  // ****************************************************************
  function automatic ksx_pos_t ksx_seg_len(input ksx_slot_t slot, input logic [7:0] j);
    ksx_seg_len = (slot == KSX_SLOT_HALF) ? ksx_pos_t'(`KSX_HALF_BASE + {3'h0, j})
                                          : `KSX_DOUBLE_LEN;
  endfunction

  function automatic ksx_pos_t ksx_pay_len(input ksx_slot_t slot, input ksx_fmt_t fmt,
                                           input logic [7:0] j);
    if (slot == KSX_SLOT_HALF)
      ksx_pay_len = ksx_pos_t'(`KSX_HALF_PAYLOAD + {3'h0, j});
    else if (fmt == KSX_FMT_SINGLE)
      ksx_pay_len = ksx_pos_t'(`KSX_SINGLE_DATA + `KSX_SINGLE_CHECK + `KSX_SINGLE_TRAIL);
    else
      ksx_pay_len = `KSX_DOUBLE_PAYLOAD;
  endfunction

  // ****************************************************************
  // whether keystream bit pos is applied to its field bit
  // ****************************************************************
  // payload bit i pairs with keystream bit i+40 up to the segment end, so check bits
  // simply fall on the unused keystream positions
  function automatic logic ksx_apply(input ksx_pos_t pos, input ksx_slot_t slot,
                                     input ksx_fmt_t fmt, input logic tail_ctl);
    ksx_pos_t off;
    off = ksx_pos_t'(pos - `KSX_TAIL_LEN);
    if (pos < `KSX_TAIL_LEN)
      ksx_apply = tail_ctl;
    else if (fmt == KSX_FMT_UNPROT)
      ksx_apply = 1'b1;
    else if (fmt == KSX_FMT_SINGLE)
      ksx_apply = (off < `KSX_SINGLE_DATA);
    else if (slot == KSX_SLOT_HALF && pos >= `KSX_HALF_BASE)
      ksx_apply = 1'b1;
    else
      ksx_apply = ((off % `KSX_SUB_PITCH) < `KSX_SUB_DATA);
  endfunction

endpackage

/* ksx_slot_end.sv */
// slot framing end: streams tail bits 8..47 then payload bits of each of
// the two data fields and applies the keystream to them bit by bit.
// assumes: same clock as the keystream end; one field bit in per cycle.
`timescale 1ns/10ps
`include "ksx_cfg.svh"

module ksx_slot_end
  import ksx_pkg::*;
#(
  parameter int J_W = 6
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ce,
  input  wire logic           start,
  input  wire ksx_slot_t      cfg_slot,
  input  wire ksx_fmt_t       cfg_fmt,
  input  wire logic [J_W-1:0] cfg_j,
  input  wire logic           din_valid,
  output logic                din_ready,
  input  wire logic           din_bit,
  output logic                dout_valid,
  input  wire logic           dout_ready,
  output logic                dout_bit,
  output logic                dout_field,
  output logic                dout_last,
  output logic                sync_error,
  ksx_link_if.mac             link
);

  if (J_W < 1 || J_W > 8) begin : g_bad_jw
    $error("ksx_slot_end: J_W must lie in 1..8");
  end

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } ksx_mac_state_t;

  ksx_mac_state_t state_reg;
  ksx_pos_t       kss_reg;
  ksx_pos_t       flen_reg;
  ksx_pos_t       idx_reg;
  logic           field_reg;
  logic           out_valid_reg;
  logic           out_bit_reg;
  logic           out_field_reg;
  logic           out_last_reg;
  logic           err_reg;

  logic           room;
  logic           need_ks;
  logic           take;
  logic           last_bit;

  // ****************************************************************
  // handshakes
  // ****************************************************************
  // trailer bits past the segment end pass in clear with no keystream
  assign room      = !out_valid_reg || dout_ready;
  assign need_ks   = idx_reg < kss_reg;
  assign din_ready = ce && (state_reg == ST_RUN) && room && (!need_ks || link.ks_valid);
  assign take      = ce && din_valid && din_ready;
  assign last_bit  = field_reg && (idx_reg == ksx_pos_t'(flen_reg - 11'h001));
  assign link.ks_ready = (state_reg == ST_RUN) && room && need_ks && din_valid && ce;

  assign dout_valid = out_valid_reg;
  assign dout_bit   = out_bit_reg;
  assign dout_field = out_field_reg;
  assign dout_last  = out_last_reg;
  assign sync_error = err_reg;

  // ****************************************************************
  // frame walk
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      kss_reg   <= '0;
      flen_reg  <= '0;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_RUN;
            kss_reg   <= ksx_seg_len(cfg_slot, 8'(cfg_j));
            flen_reg  <= ksx_pos_t'(`KSX_TAIL_LEN + ksx_pay_len(cfg_slot, cfg_fmt, 8'(cfg_j)));
          end
        end
        ST_RUN: begin
          if (take && last_bit) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_reg   <= '0;
      field_reg <= 1'b0;
    end else if (ce && state_reg == ST_IDLE) begin
      idx_reg   <= '0;
      field_reg <= 1'b0;
    end else if (take) begin
      if (idx_reg == ksx_pos_t'(flen_reg - 11'h001)) begin
        idx_reg   <= '0;
        field_reg <= !field_reg;
      end else begin
        idx_reg <= ksx_pos_t'(idx_reg + 11'h001);
      end
    end
  end

  // ****************************************************************
  // exclusive-or stage; same path for encrypt and decrypt
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid_reg <= 1'b0;
    end else if (ce) begin
      if (take) begin
        out_valid_reg <= 1'b1;
      end else if (dout_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_bit_reg   <= 1'b0;
      out_field_reg <= 1'b0;
      out_last_reg  <= 1'b0;
    end else if (take) begin
      out_bit_reg   <= din_bit ^ (need_ks && link.ks_bit && link.ks_apply);
      out_field_reg <= field_reg;
      out_last_reg  <= last_bit;
    end
  end

  // catches a keystream stream out of step with the field bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else if (ce) begin
      err_reg <= take && need_ks && (link.ks_pos != idx_reg || link.ks_seg != field_reg);
    end
  end

endmodule

/* slot_keystream_xor_mapper_tb.sv */
// self-checking bench: both ends joined by the link, random frames.
// assumes: design files compiled first; run ends in summarize.
`timescale 1ns/10ps

module slot_keystream_xor_mapper_tb;
  import ksx_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start_k = 1'b0;
  logic        start_s = 1'b0;
  ksx_slot_t   slot = KSX_SLOT_HALF;
  ksx_fmt_t    fmt = KSX_FMT_UNPROT;
  logic        tail_ctl = 1'b0;
  logic        enc = 1'b0;
  logic [5:0]  j = 6'h00;
  logic        kin_valid = 1'b0;
  logic        kin_bit = 1'b0;
  logic        din_valid = 1'b0;
  logic        din_bit = 1'b0;
  logic        dout_ready = 1'b0;
  logic        ce = 1'b1;
  logic        kin_ready, busy, done, cfg_error, din_ready;
  logic        dout_valid, dout_bit, dout_field, dout_last, sync_error;
  logic [31:0] seed = 32'h77a5;
  logic [31:0] r;
  logic        slow = 1'b0;
  logic        tk, td;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          errs = 0;
  int          dones = 0;
  int          syncs = 0;
  logic        ks_q[$], din_q[$], out_q[$], fld_q[$], lst_q[$];
  ksx_slot_t   stab[5] = '{KSX_SLOT_HALF, KSX_SLOT_HALF, KSX_SLOT_DOUBLE, KSX_SLOT_DOUBLE,
                           KSX_SLOT_DOUBLE};
  ksx_fmt_t    ftab[5] = '{KSX_FMT_UNPROT, KSX_FMT_MULTI, KSX_FMT_UNPROT, KSX_FMT_MULTI,
                           KSX_FMT_SINGLE};

  always #5 clk = ~clk;

  ksx_link_if link ();
  ksx_keystream_end #(.J_W(6)) i_ksx_keystream_end (
    .clk(clk), .rst(rst), .ce(ce), .start(start_k), .cfg_slot(slot), .cfg_fmt(fmt),
    .cfg_tail_ctl(tail_ctl), .cfg_encrypt(enc), .cfg_j(j), .kin_valid(kin_valid),
    .kin_ready(kin_ready), .kin_bit(kin_bit), .busy(busy), .done(done),
    .cfg_error(cfg_error), .link(link.gen));
  ksx_slot_end #(.J_W(6)) i_ksx_slot_end (
    .clk(clk), .rst(rst), .ce(ce), .start(start_s), .cfg_slot(slot), .cfg_fmt(fmt),
    .cfg_j(j), .din_valid(din_valid), .din_ready(din_ready), .din_bit(din_bit),
    .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_bit(dout_bit),
    .dout_field(dout_field), .dout_last(dout_last), .sync_error(sync_error),
    .link(link.mac));
  ksx_link_chk i_ksx_link_chk (
    .clk(clk), .rst(rst), .ks_valid(link.ks_valid), .ks_ready(link.ks_ready),
    .ks_bit(link.ks_bit), .ks_apply(link.ks_apply), .ks_pos(link.ks_pos),
    .ks_seg(link.ks_seg), .ks_last(link.ks_last));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // which field bit k takes the keystream, when encrypting
  function automatic logic mask(int k);
    if (k < 40) return tail_ctl;
    if (fmt == KSX_FMT_UNPROT) return 1'b1;
    if (fmt == KSX_FMT_SINGLE) return k < 808;
    if (slot == KSX_SLOT_HALF && k >= 120) return 1'b1;
    return (k - 40) % 80 < 64;
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ********
  // monitor and random sources
  // ********
  // sources hold an offer until taken, so stalls never drop a bit
  always @(posedge clk) begin
    tk = kin_valid && kin_ready;
    td = din_valid && din_ready;
    if (!rst && tk) ks_q.push_back(kin_bit);
    if (!rst && td) din_q.push_back(din_bit);
    // outputs and pulses hold while ce is low, so count only on live edges
    if (!rst && ce && dout_valid && dout_ready) begin
      out_q.push_back(dout_bit);
      fld_q.push_back(dout_field);
      lst_q.push_back(dout_last);
    end
    errs += cfg_error & ce;
    dones += done & ce;
    syncs += sync_error & ce;
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
    #1;
    r = rnd();
    if (tk || !kin_valid) begin
      kin_valid = !slow || r[2:1] != 2'h0;
      kin_bit = r[0];
    end
    if (td || !din_valid) begin
      din_valid = !slow || r[5:4] != 2'h0;
      din_bit = r[3];
    end
    dout_ready = !slow || r[7:6] != 2'h0;
    ce = !slow || r[10:8] != 3'h0;
  end

  task automatic frame(ksx_slot_t s, ksx_fmt_t f, logic [5:0] jj, logic t, logic e);
    int   len;
    int   flen;
    int   n;
    int   k;
    logic x;
    slot = s;
    fmt = f;
    j = jj;
    tail_ctl = t;
    enc = e;
    len = s == KSX_SLOT_HALF ? 120 + jj : 840;
    flen = 40 + (s == KSX_SLOT_HALF ? 80 + jj : f == KSX_FMT_SINGLE ? 804 : 800);
    ks_q.delete();
    din_q.delete();
    out_q.delete();
    fld_q.delete();
    lst_q.delete();
    dones = 0;
    syncs = 0;
    errs = 0;
    start_k = 1'b1;
    start_s = 1'b1;
    @(posedge clk);
    while (!ce) @(posedge clk);
    #1;
    start_k = 1'b0;
    start_s = 1'b0;
    n = 0;
    while ((busy || out_q.size() < 2 * flen) && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20000) begin
      miscompares++;
      summarize();
    end
    @(posedge clk);
    #1;
    check("ks_count", 16'(ks_q.size()), 16'(2 * len));
    check("dout_count", 16'(out_q.size()), 16'(2 * flen));
    check("done", 16'(dones), 16'h0001);
    check("sync_error", 16'(syncs), 16'h0000);
    check("frame_cfg_error", 16'(errs), 16'h0000);
    for (int i = 0; i < out_q.size() && i < 2 * flen; i++) begin
      k = i % flen;
      x = k < len ? ks_q[(i / flen) * len + k] : 1'b0;
      x = din_q[i] ^ (x & e & mask(k));
      check("dout_bit", {15'h0, out_q[i]}, {15'h0, x});
      check("dout_field", {15'h0, fld_q[i]}, 16'(i / flen));
      check("dout_last", {15'h0, lst_q[i]}, 16'(i == 2 * flen - 1));
    end
  endtask

  task automatic refuse(ksx_slot_t s, ksx_fmt_t f, logic [5:0] jj);
    slot = s;
    fmt = f;
    j = jj;
    errs = 0;
    ks_q.delete();
    start_k = 1'b1;
    @(posedge clk);
    while (!ce) @(posedge clk);
    #1;
    start_k = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("cfg_error", 16'(errs), 16'h0001);
    check("refused_ks", 16'(ks_q.size()), 16'h0000);
    check("refused_busy", {15'h0, busy}, 16'h0000);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    // corner j values in tests 0 and 5, random on the other half-slot tests, with clear mode once
    for (int n = 0; n < 12; n++) begin
      r = rnd();
      slow = n[1];
      frame(stab[n % 5], ftab[n % 5],
            stab[n % 5] != KSX_SLOT_HALF ? 6'h00 : n == 0 ? 6'h00 : n == 5 ? 6'h3f : r[5:0],
            r[8], n != 7);
      $display("test %0d done", n);
    end
    slow = 1'b0;
    refuse(KSX_SLOT_HALF, KSX_FMT_SINGLE, 6'h00);
    refuse(KSX_SLOT_DOUBLE, KSX_FMT_UNPROT, 6'h05);
    refuse(KSX_SLOT_HALF, ksx_fmt_t'(2'h3), 6'h00);
    $display("test refusals done");
    summarize();
  end
endmodule
